// ---- core/ecfg_defs.svh ----
`ifndef ECFG_DEFS_SVH
`define ECFG_DEFS_SVH

// register byte addresses
`define ECFG_ADDR_CFG1 16'h7FD8
`define ECFG_ADDR_CFG2 16'h7FD9
`define ECFG_ADDR_SA0 16'h7FDA
`define ECFG_ADDR_SA5 16'h7FDF
`define ECFG_ADDR_INT_STAT 16'h7FF0
`define ECFG_ADDR_INT_MASK 16'h7FF1
`define ECFG_ADDR_TX_CTRL 16'h7FF2
`define ECFG_ADDR_PKT_PORT 16'h7FF3

// field positions
`define ECFG_CFG1_PORT_SEL 0
`define ECFG_CFG1_LOW_SQ 1
`define ECFG_CFG1_FULL_STEP 2
`define ECFG_CFG2_AUTO_REL 0
`define ECFG_CFG2_CLK_GATE 1
`define ECFG_CFG2_MASK 8'h03
`define ECFG_TXC_ENABLE 0
`define ECFG_INT_TX 0
`define ECFG_INT_EMPTY 1
`define ECFG_INT_W 2

// reset values
`define ECFG_RST_BYTE 8'h00

// squelch thresholds in millivolts
`define ECFG_SQUELCH_LOW_MV 9'd240
`define ECFG_SQUELCH_STD_MV 9'd400

`endif

// ---- core/ecfg_pkg.sv ----
package ecfg_pkg;
  typedef enum logic [1:0] {TXS_IDLE, TXS_RUN, TXS_HALT} ecfg_txst_t;
  typedef logic [7:0] ecfg_byte_t;
endpackage

// ---- core/ecfg_tx_if.sv ----
`timescale 1ns/100ps
interface ecfg_tx_if #(parameter int PKT_W = 6);
  logic auto_release;
  logic en_set;
  logic done;
  logic ok;
  logic fatal;
  logic empty;
  logic [PKT_W-1:0] pkt;
  logic tx_enable;
  logic rel_pg;
  logic push;
  logic ev_tx;
  logic ev_empty;
  logic [PKT_W-1:0] out_pkt;
  logic [PKT_W-1:0] fail_pkt;
  modport seq (input auto_release, en_set, done, ok, fatal, empty, pkt,
    output tx_enable, rel_pg, push, ev_tx, ev_empty, out_pkt, fail_pkt);
  modport ctl (output auto_release, en_set, done, ok, fatal, empty, pkt,
    input tx_enable, rel_pg, push, ev_tx, ev_empty, out_pkt, fail_pkt);
endinterface

// ---- core/ecfg_irq.sv ----
`timescale 1ns/100ps
module ecfg_irq #(parameter int W = 2)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_evt,
  input wire logic i_clr_wr,
  input wire logic i_mask_wr,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_status,
  output logic [W-1:0] o_mask,
  output logic o_irq
);
  logic [W-1:0] stat_ff;
  logic [W-1:0] mask_ff;
  logic [W-1:0] nxt_stat;
  logic [W-1:0] nxt_mask;

  always_comb
  begin
    // a new event wins over a write-one clear in the same cycle
    nxt_stat = (stat_ff & ~(i_clr_wr ? i_wdata : '0)) | i_evt;
    nxt_mask = i_mask_wr ? i_wdata : mask_ff;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      stat_ff <= '0;
      mask_ff <= '0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  assign o_status = stat_ff;
  assign o_mask = mask_ff;
  assign o_irq = |(stat_ff & mask_ff);

  sticky_set_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_evt != '0) |=> ((o_status & $past(i_evt)) == $past(i_evt)))
    else $error("event bit not latched");
endmodule

// ---- core/ecfg_txq.sv ----
`timescale 1ns/100ps
module ecfg_txq
  import ecfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  ecfg_tx_if.seq tx
);
  ecfg_txst_t st_ff;
  ecfg_txst_t nxt_st;
  logic rel_ff;
  logic push_ff;
  logic evtx_ff;
  logic evempty_ff;
  logic [$bits(tx.pkt)-1:0] out_ff;
  logic [$bits(tx.pkt)-1:0] fail_ff;
  logic nxt_rel;
  logic nxt_push;
  logic nxt_evtx;
  logic nxt_evempty;
  logic [$bits(tx.pkt)-1:0] nxt_out;
  logic [$bits(tx.pkt)-1:0] nxt_fail;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_rel = 1'b0;
    nxt_push = 1'b0;
    nxt_evtx = 1'b0;
    nxt_evempty = 1'b0;
    nxt_out = out_ff;
    nxt_fail = fail_ff;
    case (st_ff)
      TXS_IDLE:
      begin
        if (tx.en_set)
          nxt_st = TXS_RUN;
      end
      TXS_RUN:
      begin
        if (tx.done && tx.ok)
        begin
          nxt_out = tx.pkt;
          if (!tx.auto_release)
            nxt_rel = 1'b1;
          else
          begin
            nxt_push = 1'b1;
            nxt_evtx = 1'b1;
          end
          nxt_evempty = tx.empty;
        end
        else if (tx.done && tx.fatal)
        begin
          // pages stay allocated so software can restart the chain
          nxt_st = TXS_HALT;
          nxt_fail = tx.pkt;
          nxt_evtx = 1'b1;
        end
        else if (tx.done)
        begin
          // non-fatal failure keeps its status word
          nxt_out = tx.pkt;
          nxt_push = 1'b1;
          nxt_evtx = tx.auto_release;
          nxt_evempty = tx.empty;
        end
      end
      TXS_HALT:
      begin
        if (tx.en_set)
          nxt_st = TXS_RUN;
      end
      default:
        nxt_st = TXS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      st_ff <= TXS_IDLE;
      rel_ff <= 1'b0;
      push_ff <= 1'b0;
      evtx_ff <= 1'b0;
      evempty_ff <= 1'b0;
      out_ff <= '0;
      fail_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      rel_ff <= nxt_rel;
      push_ff <= nxt_push;
      evtx_ff <= nxt_evtx;
      evempty_ff <= nxt_evempty;
      out_ff <= nxt_out;
      fail_ff <= nxt_fail;
    end
  end

  assign tx.tx_enable = (st_ff == TXS_RUN);
  assign tx.rel_pg = rel_ff;
  assign tx.push = push_ff;
  assign tx.ev_tx = evtx_ff;
  assign tx.ev_empty = evempty_ff;
  assign tx.out_pkt = out_ff;
  assign tx.fail_pkt = fail_ff;

  fatal_halt_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (tx.tx_enable && tx.done && !tx.ok && tx.fatal)
    |=> !tx.tx_enable ##1 (!tx.tx_enable || $past(tx.en_set)))
    else $error("transmit kept running after fatal error");
  fail_pkt_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (tx.tx_enable && tx.done && !tx.ok && tx.fatal)
    |=> (tx.fail_pkt == $past(tx.pkt)) && !tx.rel_pg)
    else $error("failing packet not held or pages released");
  auto_free_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (tx.tx_enable && tx.done && tx.ok && !tx.auto_release)
    |=> tx.rel_pg && !tx.push && (tx.out_pkt == $past(tx.pkt)))
    else $error("successful frame not freed quietly");
  auto_irq_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (tx.ev_tx && !$past(tx.auto_release)) |-> !tx.tx_enable)
    else $error("per-frame interrupt in auto-free mode");
  tx_fatal_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    tx.tx_enable && tx.done && tx.fatal ##[1:20] tx.tx_enable);
  tx_drain_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    tx.ev_empty && !tx.push);
endmodule

// ---- core/ecfg_top.sv ----
`timescale 1ns/100ps
`include "ecfg_defs.svh"

module ecfg_top
  import ecfg_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PKT_W = 6,
  parameter int SA_BYTES = 6
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_usb_suspend,
  input wire logic i_tx_done,
  input wire logic i_tx_ok,
  input wire logic i_tx_fatal,
  input wire logic i_tx_chain_empty,
  input wire logic [PKT_W-1:0] i_tx_pkt,
  output logic o_tx_enable,
  output logic o_tx_release,
  output logic o_tx_done_push,
  output logic [PKT_W-1:0] o_tx_out_pkt,
  output logic o_attachment_port_select,
  output logic o_aui_full_step,
  output logic o_low_squelch,
  output logic [8:0] o_squelch_mv,
  output logic o_eth_clk_run,
  output logic o_codec_enable,
  output logic [8*SA_BYTES-1:0] o_station_addr,
  output logic o_irq
);
  ecfg_byte_t cfg1_ff;
  ecfg_byte_t cfg2_ff;
  ecfg_byte_t sa_ff [SA_BYTES];
  ecfg_byte_t rdata_ff;
  logic clk_run_ff;
  ecfg_byte_t nxt_cfg1;
  ecfg_byte_t nxt_cfg2;
  ecfg_byte_t nxt_sa [SA_BYTES];
  ecfg_byte_t nxt_rdata;
  logic nxt_clk_run;
  logic sa_hit;
  logic [ADDR_W-1:0] sa_off;
  logic [`ECFG_INT_W-1:0] int_stat;
  logic [`ECFG_INT_W-1:0] int_mask;
  logic [`ECFG_INT_W-1:0] int_evt;

  ecfg_tx_if #(.PKT_W(PKT_W)) txb ();

  assign sa_off = i_addr - `ECFG_ADDR_SA0;
  assign sa_hit = (i_addr >= `ECFG_ADDR_SA0) && (i_addr <= `ECFG_ADDR_SA5);

  // configuration and address registers
  always_comb
  begin
    nxt_cfg1 = cfg1_ff;
    nxt_cfg2 = cfg2_ff;
    for (int i = 0; i < SA_BYTES; i++)
      nxt_sa[i] = sa_ff[i];
    if (i_wr)
    begin
      if (i_addr == `ECFG_ADDR_CFG1)
        nxt_cfg1 = i_wdata;
      if (i_addr == `ECFG_ADDR_CFG2)
        nxt_cfg2 = i_wdata & `ECFG_CFG2_MASK;
      if (sa_hit)
        nxt_sa[sa_off[2:0]] = i_wdata;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      cfg1_ff <= `ECFG_RST_BYTE;
      cfg2_ff <= `ECFG_RST_BYTE;
      for (int i = 0; i < SA_BYTES; i++)
        sa_ff[i] <= `ECFG_RST_BYTE;
    end
    else
    begin
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= nxt_cfg2;
      for (int i = 0; i < SA_BYTES; i++)
        sa_ff[i] <= nxt_sa[i];
    end
  end

  // byte 0 lands in the low bits so bit 0 leaves first on the wire
  always_comb
  begin
    for (int i = 0; i < SA_BYTES; i++)
      o_station_addr[8*i +: 8] = sa_ff[i];
  end

  assign o_attachment_port_select = cfg1_ff[`ECFG_CFG1_PORT_SEL];
  // full step has no meaning on twisted pair, so it is masked there
  assign o_aui_full_step = cfg1_ff[`ECFG_CFG1_FULL_STEP] &
    cfg1_ff[`ECFG_CFG1_PORT_SEL];
  assign o_low_squelch = cfg1_ff[`ECFG_CFG1_LOW_SQ];
  assign o_squelch_mv = o_low_squelch ? `ECFG_SQUELCH_LOW_MV :
    `ECFG_SQUELCH_STD_MV;

  // ethernet clock and codec run flag
  always_comb
  begin
    nxt_clk_run = !(cfg2_ff[`ECFG_CFG2_CLK_GATE] && i_usb_suspend);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      clk_run_ff <= 1'b1;
    else
      clk_run_ff <= nxt_clk_run;
  end

  // one flag drives both so the codec never runs without its clock
  assign o_eth_clk_run = clk_run_ff;
  assign o_codec_enable = clk_run_ff;

  // transmit completion sequencer
  assign txb.auto_release = cfg2_ff[`ECFG_CFG2_AUTO_REL];
  assign txb.en_set = i_wr && (i_addr == `ECFG_ADDR_TX_CTRL) &&
    i_wdata[`ECFG_TXC_ENABLE];
  assign txb.done = i_tx_done;
  assign txb.ok = i_tx_ok;
  assign txb.fatal = i_tx_fatal;
  assign txb.empty = i_tx_chain_empty;
  assign txb.pkt = i_tx_pkt;

  ecfg_txq u_txq (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .tx(txb.seq)
  );

  assign o_tx_enable = txb.tx_enable;
  assign o_tx_release = txb.rel_pg;
  assign o_tx_done_push = txb.push;
  assign o_tx_out_pkt = txb.out_pkt;

  // interrupt status, write one to clear
  assign int_evt[`ECFG_INT_TX] = txb.ev_tx;
  assign int_evt[`ECFG_INT_EMPTY] = txb.ev_empty;

  ecfg_irq #(.W(`ECFG_INT_W)) u_irq (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_evt(int_evt),
    .i_clr_wr(i_wr && (i_addr == `ECFG_ADDR_INT_STAT)),
    .i_mask_wr(i_wr && (i_addr == `ECFG_ADDR_INT_MASK)),
    .i_wdata(i_wdata[`ECFG_INT_W-1:0]),
    .o_status(int_stat),
    .o_mask(int_mask),
    .o_irq(o_irq)
  );

  // read data valid only in the cycle after the strobe
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (i_rd)
    begin
      if (sa_hit)
        nxt_rdata = sa_ff[sa_off[2:0]];
      else
      begin
        case (i_addr)
          `ECFG_ADDR_CFG1: nxt_rdata = cfg1_ff;
          `ECFG_ADDR_CFG2: nxt_rdata = cfg2_ff;
          `ECFG_ADDR_INT_STAT: nxt_rdata = {6'h00, int_stat};
          `ECFG_ADDR_INT_MASK: nxt_rdata = {6'h00, int_mask};
          `ECFG_ADDR_TX_CTRL: nxt_rdata = {7'h00, txb.tx_enable};
          `ECFG_ADDR_PKT_PORT: nxt_rdata = {2'h0, txb.fail_pkt};
          default: nxt_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_rdata = rdata_ff;

  port_sel_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_wr && i_addr == `ECFG_ADDR_CFG1)
    |=> o_attachment_port_select == $past(i_wdata[`ECFG_CFG1_PORT_SEL]))
    else $error("port select not taken on next edge");
  full_step_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_wr && i_addr == `ECFG_ADDR_CFG1)
    |=> o_aui_full_step ==
    $past(i_wdata[`ECFG_CFG1_FULL_STEP] & i_wdata[`ECFG_CFG1_PORT_SEL]))
    else $error("full step outside AUI mode");
  squelch_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_wr && i_addr == `ECFG_ADDR_CFG1 && i_wdata[`ECFG_CFG1_LOW_SQ])
    |=> o_squelch_mv == 9'd240)
    else $error("low squelch threshold wrong");
  clk_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (cfg2_ff[`ECFG_CFG2_CLK_GATE] && i_usb_suspend)
    |=> !o_eth_clk_run && !o_codec_enable)
    else $error("ethernet clock not stopped in suspend");
  sa0_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_wr && i_addr == `ECFG_ADDR_SA0) |=> o_station_addr[7:0] == $past(i_wdata))
    else $error("address byte 0 not stored in low bits");
  sa1_rd_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd && i_addr == 16'h7FDB)
    |=> o_rdata == $past(o_station_addr[15:8]))
    else $error("address byte 1 readback wrong");
  reserved_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd && i_addr == `ECFG_ADDR_CFG2) |=> o_rdata[7:2] == 6'h00)
    else $error("reserved bits not zero");

  // register bus, squelch and clock run checks
  rdata_idle_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  cfg1_rd_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd && i_addr == `ECFG_ADDR_CFG1) |=> o_rdata == $past(cfg1_ff))
    else $error("config 1 readback wrong");
  unmapped_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd && i_addr == 16'h7FE0) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  squelch_std_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_wr && i_addr == `ECFG_ADDR_CFG1 && !i_wdata[`ECFG_CFG1_LOW_SQ])
    |=> o_squelch_mv == 9'd400 && !o_low_squelch)
    else $error("standard squelch threshold wrong");
  clk_run_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(cfg2_ff[`ECFG_CFG2_CLK_GATE] && i_usb_suspend)
    |=> o_eth_clk_run && o_codec_enable)
    else $error("ethernet clock stopped without gate");

  // every address byte lands in its own slice
  for (genvar g = 0; g < SA_BYTES; g++)
  begin
    sa_byte_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_wr && i_addr == `ECFG_ADDR_SA0 + 16'(g))
      |=> o_station_addr[8*g +: 8] == $past(i_wdata))
      else $error("address byte write lost");
  end

  // transmit and interrupt checks
  tx_restart_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (txb.en_set && !o_tx_enable) |=> o_tx_enable)
    else $error("transmit did not restart");
  txctl_rd_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd && i_addr == `ECFG_ADDR_TX_CTRL) |=> o_rdata == {7'h00, $past(o_tx_enable)})
    else $error("transmit enable readback wrong");
  pkt_port_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd && i_addr == `ECFG_ADDR_PKT_PORT) |=> o_rdata[PKT_W-1:0] == $past(txb.fail_pkt))
    else $error("packet number port readback wrong");
  halt_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !o_tx_enable |=> !o_tx_release && !o_tx_done_push)
    else $error("frame processed while transmit disabled");
  auto_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (o_tx_enable && i_tx_done && i_tx_ok && !cfg2_ff[`ECFG_CFG2_AUTO_REL])
    |=> !txb.ev_tx)
    else $error("per-frame event on freed frame");
  drain_stat_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (o_tx_enable && i_tx_done && i_tx_chain_empty && (i_tx_ok || !i_tx_fatal))
    |-> ##2 int_stat[`ECFG_INT_EMPTY])
    else $error("drained chain not flagged");
  fatal_irq_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (o_tx_enable && i_tx_done && !i_tx_ok && i_tx_fatal)
    |-> ##2 int_stat[`ECFG_INT_TX])
    else $error("fatal frame not flagged");
  irq_clear_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_wr && i_addr == `ECFG_ADDR_INT_STAT && i_wdata[1:0] == 2'h3 && int_evt == 2'h0)
    |=> !o_irq)
    else $error("interrupt stayed after clear");

  irq_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    !o_irq ##1 o_irq);
  drain_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    o_tx_enable && i_tx_done && i_tx_chain_empty ##2 o_irq);
  suspend_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    o_eth_clk_run ##1 !o_eth_clk_run ##[1:50] o_eth_clk_run);
endmodule

// ---- bench/ecfg_line_model.sv ----
`timescale 1ns/100ps
module ecfg_line_model #(parameter int PKT_W = 6)
(
  input wire logic i_mclk,
  output logic o_done,
  output logic o_ok,
  output logic o_fatal,
  output logic o_last,
  output logic [PKT_W-1:0] o_pkt
);
  initial
  begin
    o_done = 1'b0;
    o_ok = 1'b0;
    o_fatal = 1'b1;
    o_last = 1'b1;
    o_pkt = '1;
  end

  // one completion pulse; qualifiers scrambled afterwards so stale values never look valid
  task automatic frame(input logic ok, input logic fat, input logic last,
    input logic [PKT_W-1:0] pkt, input int gap);
    repeat (gap) @(posedge i_mclk);
    @(posedge i_mclk);
    o_done <= 1'b1;
    o_ok <= ok;
    o_fatal <= fat;
    o_last <= last;
    o_pkt <= pkt;
    @(posedge i_mclk);
    o_done <= 1'b0;
    o_ok <= ~ok;
    o_fatal <= ~fat;
    o_last <= ~last;
    o_pkt <= ~pkt;
  endtask
endmodule

// ---- bench/ecfg_top_tb.sv ----
`timescale 1ns/100ps
`include "ecfg_defs.svh"
module ecfg_top_tb;
  localparam logic [15:0] A_C1 = `ECFG_ADDR_CFG1;
  localparam logic [15:0] A_C2 = `ECFG_ADDR_CFG2;
  localparam logic [15:0] A_ST = `ECFG_ADDR_INT_STAT;
  localparam logic [15:0] A_MK = `ECFG_ADDR_INT_MASK;
  localparam logic [15:0] A_TX = `ECFG_ADDR_TX_CTRL;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic susp = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, d, v;
  logic done, ok, fat, last, txen, rel, push, aui, full, lsq, crun, codec, irq;
  logic [5:0] pkt, opkt;
  logic [8:0] sq_mv;
  logic [47:0] sa, exp_sa;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 32'hB42F;

  always #10 mclk = ~mclk;

  ecfg_top uut (.i_mclk(mclk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_usb_suspend(susp), .i_tx_done(done),
    .i_tx_ok(ok), .i_tx_fatal(fat), .i_tx_chain_empty(last), .i_tx_pkt(pkt),
    .o_tx_enable(txen), .o_tx_release(rel), .o_tx_done_push(push),
    .o_tx_out_pkt(opkt), .o_attachment_port_select(aui), .o_aui_full_step(full),
    .o_low_squelch(lsq), .o_squelch_mv(sq_mv), .o_eth_clk_run(crun),
    .o_codec_enable(codec), .o_station_addr(sa), .o_irq(irq));

  ecfg_line_model pm (.i_mclk(mclk), .o_done(done), .o_ok(ok), .o_fatal(fat),
    .o_last(last), .o_pkt(pkt));

  function automatic logic [8:0] sq_exp(input logic low);
    return low ? 9'h0F0 : 9'h190;
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] x);
    @(posedge mclk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string m);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e, m);
  endtask

  // ep of x skips the push check where the outcome is left open
  task automatic fchk(input logic o, input logic f, input logic l,
    input logic [5:0] p, input logic er, input logic ep);
    pm.frame(o, f, l, p, $random(seed) & 3);
    #1 chk(rel, er, "release");
    if (ep !== 1'bx)
      chk(push, ep, "push");
    if (er | (ep === 1'b1))
      chk(opkt, p, "out pkt");
  endtask

  task summarize;
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    summarize;
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++)
      rchk(i < 8 ? A_C1 + 16'(i) : A_ST + 16'(i - 8), 8'h00, "reset");
    chk({sq_mv, crun, codec, txen, irq}, {9'h190, 4'hC}, "reset out");
    for (int i = 0; i < 8; i++)
    begin
      v = 8'(i) | (8'($random(seed)) & 8'hF8);
      wreg(A_C1, v);
      #1 chk({aui, lsq, full, sq_mv}, {v[0], v[1], v[2] & v[0], sq_exp(v[1])}, "cfg1");
      rchk(A_C1, v, "cfg1 rd");
    end
    wreg(A_C2, 8'hFC);
    rchk(A_C2, 8'h00, "cfg2 reserved");
    @(posedge mclk);
    susp <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({crun, codec}, 2'h3, "no gate");
    wreg(A_C2, 8'h02);
    @(posedge mclk);
    #1 chk({crun, codec}, 2'h0, "gated");
    @(posedge mclk);
    susp <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({crun, codec}, 2'h3, "resumed");
    wreg(A_C2, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      exp_sa[8*i+:8] = v;
      wreg(`ECFG_ADDR_SA0 + 16'(i), v);
    end
    #1 chk(sa, exp_sa, "station addr");
    for (int i = 0; i < 6; i++)
      rchk(`ECFG_ADDR_SA0 + 16'(i), exp_sa[8*i+:8], "sa rd");
    wreg(16'h7FE0, 8'hA5);
    rchk(16'h7FE0, 8'h00, "unmapped");
    wreg(A_MK, 8'h03);
    wreg(A_TX, 8'h01);
    #1 chk(txen, 1'b1, "tx on");
    for (int i = 0; i < 3; i++)
    begin
      fchk(1'b1, 1'b0, i == 2, 6'(i + 9), 1'b1, 1'b0);
      @(posedge mclk);
      #1 chk(irq, i == 2, "chain irq");
    end
    rchk(A_ST, 8'h02, "drained");
    wreg(A_ST, 8'h02);
    @(posedge mclk);
    #1 chk(irq, 1'b0, "w1c");
    wreg(A_MK, 8'h02);
    fchk(1'b1, 1'b0, 1'b0, 6'h05, 1'b1, 1'b0);
    fchk(1'b0, 1'b1, 1'b0, 6'h2A, 1'b0, 1'bx);
    chk({txen, irq}, 2'h0, "fatal");
    rchk(`ECFG_ADDR_PKT_PORT, 8'h2A, "pkt port");
    rchk(A_ST, 8'h01, "fatal stat");
    fchk(1'b1, 1'b0, 1'b1, 6'h11, 1'b0, 1'b0);
    rchk(A_ST, 8'h01, "stopped");
    wreg(A_ST, 8'h01);
    wreg(A_TX, 8'h01);
    #1 chk(txen, 1'b1, "restart");
    wreg(A_C2, 8'h01);
    wreg(A_MK, 8'h01);
    fchk(1'b1, 1'b0, 1'b0, 6'h33, 1'b0, 1'b1);
    @(posedge mclk);
    #1 chk(irq, 1'b1, "tx irq");
    fchk(1'b0, 1'b0, 1'b1, 6'h1C, 1'b0, 1'b1);
    chk(txen, 1'b1, "nonfatal run");
    summarize;
  end
endmodule
